// file: pkg/output_clock_sync_pkg.sv
// constants shared by the output clock synchroniser
// assumes an apb register bus and a sample clock that runs the whole block
package output_clock_sync_pkg;

  // ==========================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_07FF;

  // ==========================================================
  // control fields
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_RST_EN_BIT = 1;
  localparam int CTRL_TRACK_BIT = 2;
  localparam int CTRL_PHASE_LSB = 3;
  localparam int CTRL_SLAVE_BIT = 5;
  localparam int CTRL_SPLIT_BIT = 6;
  localparam int CTRL_QUAD_BIT = 7;
  localparam int CTRL_QPD_BIT = 8;
  localparam int CTRL_APER_LSB = 9;

  // ==========================================================
  // status fields
  localparam int STAT_IN_RESET_BIT = 0;
  localparam int STAT_ARMED_BIT = 1;
  localparam int STAT_OUT_CLK_BIT = 2;
  localparam int STAT_PHASE_LSB = 3;
  localparam int STAT_TRACK_HIT_BIT = 5;

  // ==========================================================
  // timing in sample clock cycles, and sample width in bits
  localparam logic [2:0] SYNC_DLY_QUAD = 3'h4;
  localparam logic [2:0] SYNC_DLY_ZERO = 3'h5;
  localparam logic [1:0] TRACK_LOAD = 2'h2;
  localparam int SAMPLE_W = 10;
  localparam int OUT_DELAY = 2;
  localparam int APER_MAX = 3;

  // ==========================================================
  // output clock reset sequence
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HOLD = 3'b010,
    ST_COUNT = 3'b100
  } rst_state_t;

endpackage

// file: rtl/two_flop_sync.sv
// two flip-flop synchroniser for levels from outside the clock domain
// assumes inputs change no faster than two clock periods
module two_flop_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // two_flop_sync

// file: rtl/output_clock_sync.sv
// output clock and data synchroniser for a multi-converter system
// assumes pclk is the sample clock and software uses apb
//
// How it works
// (R1) unsplit mode: delayed buses tri-stated
// (R2) board leaves q outputs open when powered down
// (R3) reset feature needs extended control, off at reset
// (R4) i and q output clocks identical, except q clock held low when q powered down
// (R5) tracking enabled only through control register
// (R6) slave realigns on every rising reference clock edge; an armed sync edge in the same cycle wins and loads phase 0
// (R7) reference edge picks the master's phase
// (R8) fixed latency; aperture adjust shifts clock too
// (R9) system aligns masters by reset pulse
// (R10) reset pin accepted asynchronously
// (R11) split mode holds clock high during reset
// (R12) entering reset may leave one narrow pulse
// (R13) sync edge 4 or 5 cycles after release
// (R14) clock resumes after fixed output delay
// (R15) first pulse undefined, later pulses deterministic
// (R16) controller sends dummy pulse after power-on
// (R17) masters share identical phase select field
// (R18) reset release synchronised before counting
module output_clock_sync #(
  parameter int SAMPLE_W = output_clock_sync_pkg::SAMPLE_W,
  parameter int OUT_DELAY = output_clock_sync_pkg::OUT_DELAY
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [output_clock_sync_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // samples from the converter core
  input wire logic [SAMPLE_W-1:0] i_sample,
  input wire logic [SAMPLE_W-1:0] q_sample,
  // synchronisation pins
  input wire logic output_clock_reset_pin,
  input wire logic reference_phase_clock_in,
  output logic phase_clock_out_first,
  output logic phase_clock_out_second,
  // output clocks
  output logic i_channel_output_clock,
  output logic q_channel_output_clock,
  // output data buses
  output logic [SAMPLE_W-1:0] i_channel_data_bus,
  output logic [SAMPLE_W-1:0] q_channel_data_bus,
  output logic [SAMPLE_W-1:0] i_channel_delayed_bus,
  output logic i_channel_delayed_bus_oe,
  output logic [SAMPLE_W-1:0] q_channel_delayed_bus,
  output logic q_channel_delayed_bus_oe
);

  localparam int APER_MAX = output_clock_sync_pkg::APER_MAX;
  localparam int DEPTH = OUT_DELAY + APER_MAX + 1;
  localparam int PIPE_W = 1 + 4 * SAMPLE_W;

  // ==========================================================
  // register decode
  function automatic logic [1:0] reg_sel(
    input logic [output_clock_sync_pkg::ADDR_W-1:0] addr
  );
    logic [1:0] sel;
    sel = 2'h3;
    if (addr == output_clock_sync_pkg::CTRL_OFFSET) begin
      sel = 2'h0;
    end else if (addr == output_clock_sync_pkg::STATUS_OFFSET) begin
      sel = 2'h1;
    end
    return sel;
  endfunction

  logic [31:0] ctrl_r;
  logic [31:0] status;
  logic [1:0] sel;

  assign sel = reg_sel(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & (sel == 2'h3);

  // control register is the only way to reach the sync features
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= output_clock_sync_pkg::CTRL_RESET; // see (R3)
    end else if (psel && penable && pwrite && sel == 2'h0) begin
      ctrl_r <= pwdata & output_clock_sync_pkg::CTRL_MASK; // see (R5)
    end
  end

  // read data captured in the setup cycle, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (sel)
        2'h0: prdata <= ctrl_r;
        2'h1: prdata <= status;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // control decode
  logic ext_on;
  logic rst_feature;
  logic track_on;
  logic slave;
  logic split;
  logic quad;
  logic q_pd;
  logic [1:0] phase_sel;
  logic [1:0] aper;

  assign ext_on = ctrl_r[output_clock_sync_pkg::CTRL_EXT_BIT];
  assign rst_feature = ext_on
    & ctrl_r[output_clock_sync_pkg::CTRL_RST_EN_BIT]; // see (R3)
  assign slave = ctrl_r[output_clock_sync_pkg::CTRL_SLAVE_BIT];
  assign track_on = ext_on
    & ctrl_r[output_clock_sync_pkg::CTRL_TRACK_BIT] & slave; // see (R5)
  assign split = ctrl_r[output_clock_sync_pkg::CTRL_SPLIT_BIT];
  assign quad = ctrl_r[output_clock_sync_pkg::CTRL_QUAD_BIT];
  assign q_pd = ctrl_r[output_clock_sync_pkg::CTRL_QPD_BIT];
  assign phase_sel = ctrl_r[output_clock_sync_pkg::CTRL_PHASE_LSB +: 2];
  assign aper = ctrl_r[output_clock_sync_pkg::CTRL_APER_LSB +: 2];

  // ==========================================================
  // pin synchronisers
  logic [1:0] pins_s;
  logic rst_pin_s;
  logic ref_s;
  logic ref_prev_r;
  logic ref_rise;

  // async reset pin and reference clock both cross here
  two_flop_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in({output_clock_reset_pin, reference_phase_clock_in}),
    .sync_out(pins_s)
  ); // see (R10) see (R18)

  assign rst_pin_s = pins_s[1];
  assign ref_s = pins_s[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_r <= 1'b0;
    end else begin
      ref_prev_r <= ref_s;
    end
  end

  assign ref_rise = ref_s & ~ref_prev_r;

  // ==========================================================
  // output clock reset sequence
  output_clock_sync_pkg::rst_state_t state_r;
  logic [2:0] dly_cnt_r;
  logic sync_edge;
  logic armed_r;

  assign sync_edge = (state_r == output_clock_sync_pkg::ST_COUNT)
    && (dly_cnt_r == 3'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= output_clock_sync_pkg::ST_RUN;
      dly_cnt_r <= 3'h0;
    end else begin
      unique case (state_r)
        output_clock_sync_pkg::ST_RUN: begin
          if (rst_feature && rst_pin_s) begin
            state_r <= output_clock_sync_pkg::ST_HOLD; // see (R10)
          end
        end
        output_clock_sync_pkg::ST_HOLD: begin
          if (!rst_pin_s) begin
            state_r <= output_clock_sync_pkg::ST_COUNT;
            dly_cnt_r <= quad
              ? output_clock_sync_pkg::SYNC_DLY_QUAD - 3'h1
              : output_clock_sync_pkg::SYNC_DLY_ZERO - 3'h1; // see (R13)
          end
        end
        output_clock_sync_pkg::ST_COUNT: begin
          if (dly_cnt_r == 3'h0) begin
            state_r <= output_clock_sync_pkg::ST_RUN;
          end else begin
            dly_cnt_r <= dly_cnt_r - 3'h1; // see (R13)
          end
        end
        default: begin
          state_r <= output_clock_sync_pkg::ST_RUN;
        end
      endcase
    end
  end

  // first pulse after power-on only arms the deterministic exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
    end else if (sync_edge) begin
      armed_r <= 1'b1; // see (R15)
    end
  end

  // ==========================================================
  // phase counter and tracking
  logic [1:0] phase_r;
  logic track_hit_r;
  logic [1:0] ph_sum;
  logic output_data_clock_raw;
  logic ref_out_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 2'h0;
    end else if (sync_edge && armed_r) begin
      phase_r <= 2'h0; // see (R15)
    end else if (track_on && ref_rise) begin
      phase_r <= output_clock_sync_pkg::TRACK_LOAD; // see (R6) see (R7)
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      track_hit_r <= 1'b0;
    end else if (track_on && ref_rise) begin
      track_hit_r <= (phase_r + 2'h1 == output_clock_sync_pkg::TRACK_LOAD);
    end
  end

  assign ph_sum = phase_r + phase_sel;

  // split mode: four phases; held high during reset; unsplit toggles
  always_comb begin
    if (split) begin
      output_data_clock_raw = ph_sum[1];
      if (state_r != output_clock_sync_pkg::ST_RUN) begin
        output_data_clock_raw = 1'b1; // see (R11) see (R12)
      end
    end else begin
      output_data_clock_raw = phase_r[0]; // see (R11)
    end
  end

  // master sends its clock on; slave forwards the received one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_out_r <= 1'b0;
    end else begin
      ref_out_r <= slave ? ref_s : output_data_clock_raw;
    end
  end

  assign phase_clock_out_first = ref_out_r;
  assign phase_clock_out_second = ref_out_r;

  // ==========================================================
  // sample capture onto primary and delayed buses
  logic [SAMPLE_W-1:0] i_prim_r;
  logic [SAMPLE_W-1:0] i_del_r;
  logic [SAMPLE_W-1:0] q_prim_r;
  logic [SAMPLE_W-1:0] q_del_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i_prim_r <= '0;
      i_del_r <= '0;
      q_prim_r <= '0;
      q_del_r <= '0;
    end else if (!split) begin
      i_prim_r <= i_sample; // see (R1)
      q_prim_r <= q_sample;
      i_del_r <= '0;
      q_del_r <= '0;
    end else if (!phase_r[0]) begin
      i_prim_r <= i_sample;
      q_prim_r <= q_sample;
    end else begin
      i_del_r <= i_sample;
      q_del_r <= q_sample;
    end
  end

  // ==========================================================
  // fixed latency line, aperture adjust picks a later tap
  logic [PIPE_W-1:0] pipe_r [DEPTH];
  logic [PIPE_W-1:0] tap;
  logic [PIPE_W-1:0] out_r;
  logic split_out_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_r[0] <= '0;
    end else begin
      pipe_r[0] <= {output_data_clock_raw, i_prim_r, i_del_r, q_prim_r, q_del_r};
    end
  end

  for (genvar g = 1; g < DEPTH; g++) begin : g_stage
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pipe_r[g] <= '0;
      end else begin
        pipe_r[g] <= pipe_r[g-1]; // see (R8)
      end
    end
  end

  // clock and data share one tap so adjust moves them together
  assign tap = pipe_r[OUT_DELAY + int'(aper)]; // see (R8) see (R14)

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= '0;
      split_out_r <= 1'b0;
    end else begin
      out_r <= tap;
      split_out_r <= split;
    end
  end

  // ==========================================================
  // output pins
  assign i_channel_output_clock = out_r[PIPE_W-1];
  assign q_channel_output_clock = out_r[PIPE_W-1] & ~q_pd; // see (R4)
  assign i_channel_data_bus = out_r[4*SAMPLE_W-1 -: SAMPLE_W];
  assign i_channel_delayed_bus = out_r[3*SAMPLE_W-1 -: SAMPLE_W];
  assign q_channel_data_bus =
    q_pd ? '0 : out_r[2*SAMPLE_W-1 -: SAMPLE_W];
  assign q_channel_delayed_bus = q_pd ? '0 : out_r[SAMPLE_W-1:0];
  assign i_channel_delayed_bus_oe = split_out_r; // see (R1)
  assign q_channel_delayed_bus_oe = split_out_r & ~q_pd; // see (R1)

  // ==========================================================
  // status
  always_comb begin
    status = 32'h0000_0000;
    status[output_clock_sync_pkg::STAT_IN_RESET_BIT] =
      (state_r != output_clock_sync_pkg::ST_RUN);
    status[output_clock_sync_pkg::STAT_ARMED_BIT] = armed_r;
    status[output_clock_sync_pkg::STAT_OUT_CLK_BIT] = out_r[PIPE_W-1];
    status[output_clock_sync_pkg::STAT_PHASE_LSB +: 2] = phase_r;
    status[output_clock_sync_pkg::STAT_TRACK_HIT_BIT] = track_hit_r;
  end

endmodule // output_clock_sync

// file: testbench/output_clock_sync_chk.sv
// port checks for the output clock synchroniser, bound to its top module
// assumes control writes land at the apb access edge with pready high
module output_clock_sync_chk #(
  parameter int SAMPLE_W = 10,
  parameter int OUT_DELAY = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [output_clock_sync_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic output_clock_reset_pin,
  input wire logic i_channel_output_clock,
  input wire logic q_channel_output_clock,
  input wire logic [SAMPLE_W-1:0] i_channel_delayed_bus,
  input wire logic i_channel_delayed_bus_oe,
  input wire logic [SAMPLE_W-1:0] q_channel_delayed_bus,
  input wire logic q_channel_delayed_bus_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] ctrl_r;
  logic [3:0] settle_r;
  logic acc, wr, ok, split, mapped, quiet, qon;
  assign acc = psel && penable;
  assign wr = acc && pwrite && pready
    && paddr == output_clock_sync_pkg::CTRL_OFFSET;
  assign mapped = paddr == output_clock_sync_pkg::CTRL_OFFSET
    || paddr == output_clock_sync_pkg::STATUS_OFFSET;
  assign ok = settle_r >= 4'hA;
  assign split = ctrl_r[output_clock_sync_pkg::CTRL_SPLIT_BIT];
  assign qon = !ctrl_r[output_clock_sync_pkg::CTRL_QPD_BIT];
  assign quiet = !ctrl_r[output_clock_sync_pkg::CTRL_RST_EN_BIT]
    && !ctrl_r[output_clock_sync_pkg::CTRL_TRACK_BIT];
  // ==========================================================
  // shadow of the control word and cycles since it changed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 32'h0;
    end else if (wr) begin
      ctrl_r <= pwdata & output_clock_sync_pkg::CTRL_MASK;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_r <= 4'h0;
    end else if (wr) begin
      settle_r <= 4'h0;
    end else if (!ok) begin
      settle_r <= settle_r + 4'h1;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_unsplit_oe_off: assert property (ok && !split |->
    !i_channel_delayed_bus_oe && !q_channel_delayed_bus_oe)
    else $error("delayed bus driven in unsplit mode");
  a_unsplit_bus_zero: assert property (ok && !split |->
    i_channel_delayed_bus == '0 && q_channel_delayed_bus == '0)
    else $error("delayed bus data in unsplit mode");
  a_split_oe_on: assert property (ok && split && qon |->
    i_channel_delayed_bus_oe && q_channel_delayed_bus_oe)
    else $error("delayed bus idle in split mode");
  a_iq_clk_same: assert property (ok && qon |->
    i_channel_output_clock == q_channel_output_clock)
    else $error("i and q output clocks differ");
  a_unsplit_toggle: assert property (ok && !split && quiet |=>
    i_channel_output_clock != $past(i_channel_output_clock))
    else $error("unsplit output clock stopped");
  a_split_period: assert property (ok && split && quiet
    && $rose(i_channel_output_clock) |-> i_channel_output_clock[*2]
    ##1 !i_channel_output_clock[*2])
    else $error("split output clock period wrong");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && mapped |->
    pready && !pslverr)
    else $error("mapped access refused");
  a_qpd_clk_low: assert property (ok && !qon |->
    !q_channel_output_clock)
    else $error("q output clock active while powered down");
  c_split: cover property (ok && split && quiet);
  c_refused: cover property (acc && pslverr);
  c_held: cover property (output_clock_reset_pin && split);
  c_qpd: cover property (ok && !qon);
endmodule // output_clock_sync_chk

bind output_clock_sync output_clock_sync_chk #(
  .SAMPLE_W(SAMPLE_W), .OUT_DELAY(OUT_DELAY)
) chk_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .output_clock_reset_pin(output_clock_reset_pin),
  .i_channel_output_clock(i_channel_output_clock),
  .q_channel_output_clock(q_channel_output_clock),
  .i_channel_delayed_bus(i_channel_delayed_bus),
  .i_channel_delayed_bus_oe(i_channel_delayed_bus_oe),
  .q_channel_delayed_bus(q_channel_delayed_bus),
  .q_channel_delayed_bus_oe(q_channel_delayed_bus_oe)
);

// file: testbench/far_side.sv
// far side model: a master's reference clock and a reset pulse source
// assumes the bench calls raise and drop just after a pclk edge
module far_side (
  // clock
  input wire logic pclk,
  // sync pins
  output logic output_clock_reset_pin,
  output logic reference_phase_clock_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic run;
  int extra;
  // master reference, phase unrelated to pclk, optional slip
  initial begin
    output_clock_reset_pin = 1'b0;
    reference_phase_clock_in = 1'b0;
    run = 1'b0;
    extra = 0;
    #37;
    forever begin
      #(400 + extra);
      extra = 0;
      reference_phase_clock_in = run && !reference_phase_clock_in;
    end
  end
  task automatic raise();
    output_clock_reset_pin <= 1'b1;
  endtask
  task automatic drop();
    output_clock_reset_pin <= 1'b0;
  endtask
endmodule // far_side

// file: testbench/tb_top.sv
// self-checking bench for the output clock synchroniser
// assumes a zero wait apb slave and the far side model on the sync pins
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CT = output_clock_sync_pkg::CTRL_OFFSET;
  localparam logic [7:0] ST = output_clock_sync_pkg::STATUS_OFFSET;
  localparam logic [9:0] LAT = 10'(output_clock_sync_pkg::OUT_DELAY + 3);
  localparam int SYNC_EXP = 6 + int'(output_clock_sync_pkg::SYNC_DLY_QUAD)
    + output_clock_sync_pkg::OUT_DELAY;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] i_sample, q_sample;
  logic rst_pin, ref_clk, i_clk, oe_i, q_clk, pc1, pc2;
  logic [9:0] i_dat, q_dat, i_del;
  int fail_count, check_count, c1, c0, ca, d1, d2;
  output_clock_sync output_clock_sync_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_sample(i_sample),
    .q_sample(q_sample), .output_clock_reset_pin(rst_pin),
    .reference_phase_clock_in(ref_clk), .phase_clock_out_first(pc1),
    .phase_clock_out_second(pc2), .i_channel_output_clock(i_clk),
    .q_channel_output_clock(q_clk), .i_channel_data_bus(i_dat),
    .q_channel_data_bus(q_dat), .i_channel_delayed_bus(i_del),
    .i_channel_delayed_bus_oe(oe_i), .q_channel_delayed_bus(),
    .q_channel_delayed_bus_oe()
  );
  far_side far_side_inst (.pclk(pclk), .output_clock_reset_pin(rst_pin),
    .reference_phase_clock_in(ref_clk));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    i_sample <= i_sample + 10'h1;
    q_sample <= q_sample - 10'h1;
  end
  // ==========================================================
  // verdict and shared tasks
  task automatic results();
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (e !== g) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bound(input int c, lim);
    if (c >= lim) begin
      fail_count++;
      results();
    end
  endtask
  task automatic tick(inout int c);
    @(posedge pclk);
    c++;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do tick(n); while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    bound(n, 16);
  endtask
  // pulse, clock held during it, cycles from release to clock low
  task automatic measure(output int c);
    far_side_inst.raise();
    repeat (12) @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      chk("held high", 1, i_clk);
      @(posedge pclk);
    end
    far_side_inst.drop();
    c = 0;
    while (i_clk !== 1'b0 && c < 40) tick(c);
    bound(c, 40);
    repeat (10) @(posedge pclk);
  endtask
  // cycles from a reference rise to the next output clock rise
  task automatic gap(output int c);
    logic p;
    c = 0;
    while (ref_clk !== 1'b0 && c < 20) tick(c);
    while (ref_clk !== 1'b1 && c < 40) tick(c);
    bound(c, 40);
    c = 0;
    do begin
      p = i_clk;
      tick(c);
    end while (!(p === 1'b0 && i_clk === 1'b1) && c < 40);
    bound(c, 40);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {i_sample, q_sample} = '0;
    fail_count = 0;
    check_count = 0;
    repeat (16) @(posedge pclk);
    chk("reset clock", 0, i_clk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(CT, 1'b0, 32'h0);
    chk("ctrl reset", output_clock_sync_pkg::CTRL_RESET, rd);
    apb(8'h0C, 1'b0, 32'h0);
    chk("unmapped error", 1, err);
    chk("unmapped read", 0, rd);
    chk("unsplit oe", 0, oe_i);
    chk("unsplit delayed data", 0, i_del);
    chk("i data latency", 10'(i_sample - LAT), i_dat);
    chk("q data latency", 10'(q_sample + LAT), q_dat);
    apb(CT, 1'b1, 32'h0000_0001);
    far_side_inst.raise();
    repeat (12) @(posedge pclk);
    far_side_inst.drop();
    repeat (10) @(posedge pclk);
    apb(ST, 1'b0, 32'h0);
    chk("disabled pulse", 0, rd[1:0]);
    apb(CT, 1'b1, 32'h0000_0003);
    far_side_inst.raise();
    repeat (12) @(posedge pclk);
    c0 = i_clk;
    @(posedge pclk);
    chk("unsplit toggle", !c0, i_clk);
    far_side_inst.drop();
    repeat (10) @(posedge pclk);
    apb(ST, 1'b0, 32'h0);
    chk("armed", 1, rd[1]);
    apb(CT, 1'b1, 32'h0000_0041);
    repeat (17) @(posedge pclk);
    c0 = pc1;
    chk("second phase out", pc1, pc2);
    repeat (output_clock_sync_pkg::OUT_DELAY + 1) @(posedge pclk);
    chk("phase out lead", c0, i_clk);
    apb(CT, 1'b1, 32'h0000_00C3);
    measure(c1);
    apb(CT, 1'b1, 32'h0000_0043);
    measure(c0);
    apb(CT, 1'b1, 32'h0000_04C3);
    measure(ca);
    chk("quad delay step", c1 + 1, c0);
    chk("aperture shift", c1 + 2, ca);
    chk("sync edge delay", SYNC_EXP, c1);
    apb(CT, 1'b1, 32'h0000_0065);
    far_side_inst.run = 1'b1;
    repeat (30) @(posedge pclk);
    gap(d1);
    far_side_inst.extra = 300;
    repeat (30) @(posedge pclk);
    gap(d2);
    chk("slave realign", d1, d2);
    apb(CT, 1'b1, 32'h0000_0141);
    repeat (10) @(posedge pclk);
    chk("q clock powered down", 0, q_clk);
    chk("q data powered down", 0, q_dat);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("clock in reset", 0, i_clk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(ST, 1'b0, 32'h0);
    chk("armed after reset", 0, rd[1]);
    apb(CT, 1'b0, 32'h0);
    chk("ctrl after reset", output_clock_sync_pkg::CTRL_RESET, rd);
    results();
  end
endmodule // tb_top
